// file: core/eepc_pkg.sv
// Register map, field layout, timing and types of the EEPROM program/erase controller
package eepc_pkg;

  // ****************************************
  // Register indices (byte address = index * 4)
  // ****************************************
  localparam logic [7:0] EEPC_CTL_IDX = 8'h3b;
  localparam logic [7:0] EEPC_CFG_IDX = 8'h3f;
  localparam logic [7:0] EEPC_BPR_IDX = 8'h40;
  localparam logic [7:0] EEPC_ADDR_IDX = 8'h41;
  localparam logic [7:0] EEPC_DATA_IDX = 8'h42;
  localparam logic [7:0] EEPC_STAT_IDX = 8'h43;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int EEPC_CTL_PUMP = 0;
  localparam int EEPC_CTL_LATCH = 1;
  localparam int EEPC_CTL_ERASE = 2;
  localparam int EEPC_CTL_ROW = 3;
  localparam int EEPC_CTL_BYTE = 4;
  localparam int EEPC_CTL_EVEN = 6;
  localparam int EEPC_CTL_ODD = 7;
  localparam logic [7:0] EEPC_CTL_RESET = 8'h00;
  localparam logic [7:0] EEPC_CTL_MASK = 8'hdf;
  localparam int EEPC_CFG_SEC = 3;
  localparam int EEPC_CFG_EEON = 0;
  localparam logic [7:0] EEPC_CFG_RESET = 8'hff;
  localparam int EEPC_BPR_CFG = 4;
  localparam logic [7:0] EEPC_BPR_RESET = 8'h1f;
  localparam logic [7:0] EEPC_ERASED = 8'hff;
  localparam logic [1:0] EEPC_RESP_OKAY = 2'h0;
  localparam logic [1:0] EEPC_RESP_SLVERR = 2'h2;

  // ****************************************
  // Array geometry and timing
  // ****************************************
  localparam int EEPC_ARRAY_BYTES = 512;
  localparam int EEPC_ROW_BYTES = 16;
  localparam int EEPC_BLOCK_BYTES = 128;
  localparam int EEPC_CLK_PERIOD_NS = 10;
  localparam int EEPC_PUMP_ON_TIME_NS = 10000000;
  localparam int EEPC_PUMP_CYCLES =
    (EEPC_PUMP_ON_TIME_NS + EEPC_CLK_PERIOD_NS - 1) / EEPC_CLK_PERIOD_NS;

  // Mode pins {b, a}
  typedef enum logic [1:0] {
    EEPC_MODE_BOOT = 2'h0,
    EEPC_MODE_TEST = 2'h1,
    EEPC_MODE_SINGLE = 2'h2,
    EEPC_MODE_EXPANDED = 2'h3
  } eepc_mode_type;

  typedef enum logic [7:0] {
    EEPC_W_IDLE = 8'h01,
    EEPC_W_SERIAL = 8'h02,
    EEPC_W_UNPROT = 8'h04,
    EEPC_W_ERASE = 8'h08,
    EEPC_W_VERIFY = 8'h10,
    EEPC_W_RAM = 8'h20,
    EEPC_W_CFG = 8'h40,
    EEPC_W_DONE = 8'h80
  } eepc_wipe_type;

  // Latched program/erase target
  typedef struct packed {
    logic valid;
    logic is_cfg;
    logic [8:0] addr;
    logic [7:0] data;
  } eepc_target_type;

endpackage : eepc_pkg

// file: core/eepc_ctrl.sv
// EEPROM program/erase controller with setup byte, security wipe and AXI4-Lite slave
// Notes on behaviour
// - Array writes are ignored while the pump enable is set.
// - During an operation, writes to any other location than the latched one are blocked.
// - Odd and even test bits together program one column across every row of a half.
// - Control bit 5 is unimplemented and reads zero.
// - Byte bit erases one byte; else row bit erases 16 bytes; else all 512.
// - Byte, row and erase bits are writable and readable at any time.
// - Erase bit selects erase; clear selects read or program.
// - Latch enable captures program targets; clear reads the array like ROM.
// - Block protection never affects reads.
// - Pump bit always readable; writes count only while latch enable is already set.
// - Pump bit is forced low whenever latch enable is low.
// - Row and byte bits are ignored while programming.
// - Any write in the row selects it; any array write selects bulk erase.
// - Setup byte has cells plus latches; reads and operation use latches.
// - Newly programmed setup value shows only after the next reset.
// - In special modes setup bits write directly; otherwise only by programming.
// - Setup byte cells program or erase in any mode while its protect is clear.
// - Security bit zero enables security; without the option it reads as one.
// - Secured part refuses test mode and starts in bootstrap instead.
// - Secured bootstrap sends FF, unprotects, erases until blank if setup bit EEON is set, fills RAM, erases setup.
module eepc_ctrl
  import eepc_pkg::*;
#(
  parameter int PUMP_CYCLES = eepc_pkg::EEPC_PUMP_CYCLES,
  parameter bit SECURITY_OPTION = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic mode_pin_a,
  input wire logic mode_pin_b,
  output eepc_pkg::eepc_mode_type op_mode,
  output logic special_mode_flag,
  output logic security_on,
  output logic [7:0] setup_byte,
  output logic nv_latch_enable,
  output logic nv_pump_on,
  output logic boot_ready,
  output logic serial_tx_valid,
  output logic [7:0] serial_tx_data,
  input wire logic serial_tx_ready,
  output logic ram_fill_req,
  output logic [7:0] ram_fill_data,
  input wire logic ram_fill_done
);
  import eepc_pkg::*;

  localparam int CW = $clog2(PUMP_CYCLES + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(PUMP_CYCLES - 1);

  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] bpr;
    logic [8:0] arr_addr;
    eepc_target_type tgt;
    logic [CW-1:0] cnt;
    logic done;
    logic loaded;
    eepc_mode_type mode;
    logic [7:0] cfg_latch;
    eepc_wipe_type wipe;
    logic tx_valid;
    logic ram_req;
    logic aw_hold;
    logic [7:0] aw_idx;
    logic w_hold;
    logic [7:0] w_data;
    logic w_lane0;
    logic w_hi;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } eepc_state_type;

  eepc_state_type s_q;
  eepc_state_type s_d;
  logic [7:0] mem_q [EEPC_ARRAY_BYTES];
  logic [7:0] cfg_cell_q;
  logic [EEPC_ARRAY_BYTES-1:0] blank_vec;
  logic [EEPC_ARRAY_BYTES-1:0] sel_vec;
  logic apply;
  logic wipe_erase;
  logic wipe_cfg;
  logic wr_fire;
  logic rd_fire;
  logic secure_now;

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic is_mapped(input logic [7:0] idx);
    is_mapped = idx == EEPC_CTL_IDX || idx == EEPC_CFG_IDX || idx == EEPC_BPR_IDX ||
                idx == EEPC_ADDR_IDX || idx == EEPC_DATA_IDX || idx == EEPC_STAT_IDX;
  endfunction : is_mapped

  function automatic logic byte_sel(input logic [7:0] ctl, input logic [8:0] tgt,
                                    input logic [8:0] idx);
    logic hit;
    hit = 1'b0;
    if (ctl[EEPC_CTL_ERASE]) begin
      if (ctl[EEPC_CTL_BYTE]) begin
        hit = idx == tgt;
      end else if (ctl[EEPC_CTL_ROW]) begin
        hit = idx[8:4] == tgt[8:4];
      end else begin
        hit = 1'b1;
      end
    end else if (ctl[EEPC_CTL_ODD] || ctl[EEPC_CTL_EVEN]) begin
      hit = idx[8] == tgt[8] && idx[3:0] == tgt[3:0] &&
            ((idx[4] && ctl[EEPC_CTL_ODD]) || (!idx[4] && ctl[EEPC_CTL_EVEN]));
    end else begin
      hit = idx == tgt;
    end
    byte_sel = hit;
  endfunction : byte_sel

  assign secure_now = SECURITY_OPTION && !cfg_cell_q[EEPC_CFG_SEC];
  assign apply = s_q.ctl[EEPC_CTL_PUMP] && s_q.tgt.valid && !s_q.done &&
                 s_q.cnt == CNT_LAST;
  assign wipe_erase = s_q.wipe == EEPC_W_ERASE && s_q.cfg_latch[EEPC_CFG_EEON];
  assign wipe_cfg = s_q.wipe == EEPC_W_CFG;
  assign wr_fire = s_q.aw_hold && s_q.w_hold && !s_q.bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  // ****************************************
  // Array and setup cells (nonvolatile, not reset)
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < EEPC_ARRAY_BYTES; gi++) begin : g_byte
      // Protection only gates writes; reads bypass it
      assign sel_vec[gi] = byte_sel(s_q.ctl, s_q.tgt.addr, 9'(gi)) &&
                           !s_q.bpr[gi / EEPC_BLOCK_BYTES];
      assign blank_vec[gi] = &mem_q[gi];
      always_ff @(posedge core_clk) begin
        if (wipe_erase) begin
          mem_q[gi] <= EEPC_ERASED;
        end else if (apply && !s_q.tgt.is_cfg && sel_vec[gi]) begin
          // Programming only clears bits; erase restores ones
          mem_q[gi] <= s_q.ctl[EEPC_CTL_ERASE] ? EEPC_ERASED : mem_q[gi] & s_q.tgt.data;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (wipe_cfg) begin
      cfg_cell_q <= EEPC_ERASED;
    end else if (apply && s_q.tgt.is_cfg && !s_q.bpr[EEPC_BPR_CFG]) begin
      cfg_cell_q <= s_q.ctl[EEPC_CTL_ERASE] ? EEPC_ERASED : cfg_cell_q & s_q.tgt.data;
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [7:0] nc;
    logic [1:0] pins;
    nc = 8'h00;
    pins = {mode_pin_b, mode_pin_a};
    s_d = s_q;

    // Pump timer; restarts whenever the pump drops
    if (!s_q.ctl[EEPC_CTL_PUMP]) begin
      s_d.cnt = '0;
      s_d.done = 1'b0;
    end else if (s_q.tgt.valid && !s_q.done) begin
      s_d.cnt = s_q.cnt + CW'(1);
      if (apply) begin
        s_d.done = 1'b1;
      end
    end

    // Setup latches load once after reset release
    if (!s_q.loaded) begin
      s_d.loaded = 1'b1;
      s_d.cfg_latch = {cfg_cell_q[7:4], cfg_cell_q[EEPC_CFG_SEC] | ~SECURITY_OPTION,
                       cfg_cell_q[2:0]};
      s_d.mode = eepc_mode_type'(pins);
      if (secure_now && pins == EEPC_MODE_TEST) begin
        s_d.mode = EEPC_MODE_BOOT;
      end
      if (secure_now && (pins == EEPC_MODE_BOOT || pins == EEPC_MODE_TEST)) begin
        s_d.wipe = EEPC_W_SERIAL;
        s_d.tx_valid = 1'b1;
      end
    end

    // Security wipe sequence
    case (s_q.wipe)
      EEPC_W_IDLE: begin
      end
      EEPC_W_SERIAL: begin
        if (serial_tx_ready) begin
          s_d.tx_valid = 1'b0;
          s_d.wipe = EEPC_W_UNPROT;
        end
      end
      EEPC_W_UNPROT: begin
        s_d.bpr = 8'h00;
        s_d.wipe = EEPC_W_ERASE;
      end
      EEPC_W_ERASE: begin
        s_d.wipe = EEPC_W_VERIFY;
      end
      EEPC_W_VERIFY: begin
        if (!s_q.cfg_latch[EEPC_CFG_EEON] || &blank_vec) begin
          s_d.wipe = EEPC_W_RAM;
          s_d.ram_req = 1'b1;
        end else begin
          s_d.wipe = EEPC_W_SERIAL; // Retry until blank
          s_d.tx_valid = 1'b1;
        end
      end
      EEPC_W_RAM: begin
        if (ram_fill_done) begin
          s_d.ram_req = 1'b0;
          s_d.wipe = EEPC_W_CFG;
        end
      end
      EEPC_W_CFG: begin
        s_d.wipe = EEPC_W_DONE;
      end
      EEPC_W_DONE: begin
      end
      default: begin
        s_d.wipe = EEPC_W_IDLE;
      end
    endcase

    // ****************************************
    // AXI4-Lite write channel
    // ****************************************
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_hold = 1'b1;
      s_d.aw_idx = s_axi_awaddr[9:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_hold = 1'b1;
      s_d.w_data = s_axi_wdata[7:0];
      s_d.w_lane0 = s_axi_wstrb[0];
      // Bus data is only valid at the handshake, so keep address bit 8 too
      s_d.w_hi = s_axi_wdata[8];
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (wr_fire) begin
      s_d.aw_hold = 1'b0;
      s_d.w_hold = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = is_mapped(s_q.aw_idx) ? EEPC_RESP_OKAY : EEPC_RESP_SLVERR;
      if (s_q.w_lane0) begin
        case (s_q.aw_idx)
          EEPC_CTL_IDX: begin
            nc = s_q.w_data & EEPC_CTL_MASK;
            if (!s_q.ctl[EEPC_CTL_LATCH]) begin
              nc[EEPC_CTL_PUMP] = s_q.ctl[EEPC_CTL_PUMP];
            end
            nc[EEPC_CTL_PUMP] = nc[EEPC_CTL_PUMP] & nc[EEPC_CTL_LATCH];
            s_d.ctl = nc;
            if (!nc[EEPC_CTL_LATCH]) begin
              s_d.tgt = '0;
            end
          end
          EEPC_CFG_IDX: begin
            if (s_q.ctl[EEPC_CTL_LATCH]) begin
              if (!s_q.ctl[EEPC_CTL_PUMP] && (!s_q.tgt.valid || s_q.tgt.is_cfg)) begin
                s_d.tgt = '{valid: 1'b1, is_cfg: 1'b1, addr: 9'h000, data: s_q.w_data};
              end
            end else if (s_q.mode == EEPC_MODE_BOOT || s_q.mode == EEPC_MODE_TEST) begin
              s_d.cfg_latch = s_q.w_data;
            end
          end
          EEPC_BPR_IDX: begin
            s_d.bpr = s_q.w_data;
          end
          EEPC_ADDR_IDX: begin
            s_d.arr_addr = {s_q.w_lane0 & s_q.w_hi, s_q.w_data};
          end
          EEPC_DATA_IDX: begin
            // Pump on blocks all; an armed target blocks other locations
            if (s_q.ctl[EEPC_CTL_LATCH] && !s_q.ctl[EEPC_CTL_PUMP] &&
                (!s_q.tgt.valid || (!s_q.tgt.is_cfg && s_q.tgt.addr == s_q.arr_addr))) begin
              s_d.tgt = '{valid: 1'b1, is_cfg: 1'b0, addr: s_q.arr_addr, data: s_q.w_data};
            end
          end
          default: begin
          end
        endcase
      end
    end

    // ****************************************
    // AXI4-Lite read channel
    // ****************************************
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (rd_fire) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = 32'h0000_0000;
      s_d.rresp = is_mapped(s_axi_araddr[9:2]) ? EEPC_RESP_OKAY : EEPC_RESP_SLVERR;
      case (s_axi_araddr[9:2])
        EEPC_CTL_IDX: s_d.rdata[7:0] = s_q.ctl & EEPC_CTL_MASK;
        EEPC_CFG_IDX: s_d.rdata[7:0] = s_q.cfg_latch;
        EEPC_BPR_IDX: s_d.rdata[7:0] = s_q.bpr;
        EEPC_ADDR_IDX: s_d.rdata[8:0] = s_q.arr_addr;
        EEPC_DATA_IDX: begin
          if (!s_q.ctl[EEPC_CTL_LATCH]) begin
            s_d.rdata[7:0] = mem_q[s_q.arr_addr];
          end
        end
        EEPC_STAT_IDX: begin
          s_d.rdata[7:0] = {boot_ready, s_q.wipe != EEPC_W_IDLE && s_q.wipe != EEPC_W_DONE,
                            s_q.mode, security_on, s_q.done, s_q.ctl[EEPC_CTL_PUMP],
                            s_q.tgt.valid};
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '{ctl: EEPC_CTL_RESET, bpr: EEPC_BPR_RESET, mode: EEPC_MODE_SINGLE,
               cfg_latch: EEPC_CFG_RESET, wipe: EEPC_W_IDLE, bresp: EEPC_RESP_OKAY,
               rresp: EEPC_RESP_OKAY, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign s_axi_awready = !s_q.aw_hold;
  assign s_axi_wready = !s_q.w_hold;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign op_mode = s_q.mode;
  assign special_mode_flag = s_q.mode == EEPC_MODE_BOOT || s_q.mode == EEPC_MODE_TEST;
  assign security_on = !s_q.cfg_latch[EEPC_CFG_SEC];
  assign setup_byte = s_q.cfg_latch;
  assign nv_latch_enable = s_q.ctl[EEPC_CTL_LATCH];
  assign nv_pump_on = s_q.ctl[EEPC_CTL_PUMP];
  assign boot_ready = s_q.loaded && (s_q.wipe == EEPC_W_IDLE || s_q.wipe == EEPC_W_DONE);
  assign serial_tx_valid = s_q.tx_valid;
  assign serial_tx_data = EEPC_ERASED;
  assign ram_fill_req = s_q.ram_req;
  assign ram_fill_data = EEPC_ERASED;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  logic wr_data_reg;
  assign wr_data_reg = wr_fire && s_q.w_lane0 && s_q.aw_idx == EEPC_DATA_IDX;

  sequence s_unprot;
    s_q.wipe == EEPC_W_UNPROT;
  endsequence
  sequence s_erase_step;
    s_q.bpr == 8'h00 && s_q.wipe == EEPC_W_ERASE;
  endsequence

  a_pump_needs_latch: assert property (s_q.ctl[EEPC_CTL_PUMP] |-> s_q.ctl[EEPC_CTL_LATCH])
    else $error("pump on without latch enable");
  a_bit_five_zero: assert property (rd_fire && s_axi_araddr[9:2] == EEPC_CTL_IDX
    |=> !s_axi_rdata[5])
    else $error("control bit 5 set");
  a_pump_write_gated: assert property (wr_fire && s_q.aw_idx == EEPC_CTL_IDX &&
    !s_q.ctl[EEPC_CTL_LATCH] |=> !s_q.ctl[EEPC_CTL_PUMP])
    else $error("pump written without latch enable");
  a_pump_blocks_write: assert property (wr_data_reg && s_q.ctl[EEPC_CTL_PUMP]
    |=> $stable(s_q.tgt))
    else $error("array write taken while pumping");
  a_other_loc_blocked: assert property (wr_data_reg && s_q.tgt.valid &&
    (s_q.tgt.is_cfg || s_q.tgt.addr != s_q.arr_addr) |=> $stable(s_q.tgt))
    else $error("write to other location taken");
  a_byte_erase_ff: assert property (apply && !s_q.tgt.is_cfg && s_q.ctl[EEPC_CTL_ERASE] &&
    s_q.ctl[EEPC_CTL_BYTE] && !s_q.bpr[s_q.tgt.addr[8:7]] |=> mem_q[$past(s_q.tgt.addr)] == 8'hff)
    else $error("byte erase failed");
  a_byte_program: assert property (apply && !s_q.tgt.is_cfg && !s_q.ctl[EEPC_CTL_ERASE] &&
    s_q.ctl[7:6] == 2'b00 && !s_q.bpr[s_q.tgt.addr[8:7]] |=>
    mem_q[$past(s_q.tgt.addr)] == ($past(mem_q[s_q.tgt.addr]) & $past(s_q.tgt.data)))
    else $error("byte program wrong value");
  a_cfg_latch_hold: assert property (s_q.loaded && !special_mode_flag |=> $stable(s_q.cfg_latch))
    else $error("setup latch changed without reset");
  a_test_refused: assert property (s_q.loaded && security_on |-> s_q.mode != EEPC_MODE_TEST)
    else $error("secured part in test mode");
  a_wipe_order: assert property (s_unprot |=> s_erase_step ##1 s_q.wipe == EEPC_W_VERIFY)
    else $error("wipe sequence out of order");

endmodule : eepc_ctrl

// file: verification/eepc_peer.sv
// Far-side model that answers the serial and RAM-fill handshakes of the wipe
module eepc_peer #(
  parameter int DELAY = 2
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic serial_tx_valid,
  output logic serial_tx_ready,
  input wire logic ram_fill_req,
  output logic ram_fill_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt_q;
  // One-cycle answers after a stall, so a slow far side is exercised
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 0;
      serial_tx_ready <= 1'b0;
      ram_fill_done <= 1'b0;
    end else begin
      serial_tx_ready <= 1'b0;
      ram_fill_done <= 1'b0;
      if ((serial_tx_valid || ram_fill_req) && !serial_tx_ready && !ram_fill_done) begin
        cnt_q <= cnt_q + 1;
        if (cnt_q >= DELAY) begin
          cnt_q <= 0;
          serial_tx_ready <= serial_tx_valid;
          ram_fill_done <= ram_fill_req && !serial_tx_valid;
        end
      end
    end
  end
endmodule : eepc_peer

// file: verification/eepc_ctrl_bench.sv
// Self-checking bench of the EEPROM program/erase controller
module eepc_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import eepc_pkg::*;
  localparam int PUMP = 8;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, wresp, rresp;
  logic mode_pin_a = 1'b0, mode_pin_b = 1'b0;
  eepc_mode_type op_mode;
  logic special_mode_flag, security_on, nv_latch_enable, nv_pump_on, boot_ready;
  logic serial_tx_valid, serial_tx_ready, ram_fill_req, ram_fill_done;
  logic [7:0] setup_byte, serial_tx_data, ram_fill_data;
  logic [31:0] rd;
  int miscompares = 0;
  int tests_run = 0;
  typedef struct {logic [7:0] idx; logic [31:0] wv; logic [31:0] rv; logic [1:0] rsp;} row_type;
  row_type rows[6];

  always #5 core_clk = ~core_clk;

  eepc_ctrl #(.PUMP_CYCLES(PUMP), .SECURITY_OPTION(1'b1)) eepc_ctrl_i (.*);
  eepc_peer eepc_peer_i (.core_clk(core_clk), .rst_b(rst_b),
    .serial_tx_valid(serial_tx_valid), .serial_tx_ready(serial_tx_ready),
    .ram_fill_req(ram_fill_req), .ram_fill_done(ram_fill_done));

  // ****************************************
  // Bus tasks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask : chk

  task automatic wr(input logic [7:0] idx, input logic [31:0] val);
    int n;
    n = 0;
    s_axi_awaddr <= {2'b00, idx, 2'b00};
    s_axi_wdata <= val;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (n < 50) begin
      @(posedge core_clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        wresp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        n = 99;
      end
    end
    if (n != 99) chk("write answer", 32'h1, 32'h0);
    @(posedge core_clk); // Idle edge: next call must not re-raise bready in this step
  endtask : wr

  task automatic rdr(input logic [7:0] idx);
    int n;
    n = 0;
    s_axi_araddr <= {2'b00, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (n < 50) begin
      @(posedge core_clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        rd = s_axi_rdata;
        rresp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        n = 99;
      end
    end
    if (n != 99) chk("read answer", 32'h1, 32'h0);
    @(posedge core_clk); // Idle edge: next call must not re-raise rready in this step
  endtask : rdr

  task automatic arr(input logic [8:0] a, input logic [7:0] exp);
    wr(EEPC_ADDR_IDX, {23'h0, a});
    rdr(EEPC_DATA_IDX);
    chk("array byte", {24'h0, exp}, rd);
  endtask : arr

  task automatic nv_op(input logic [7:0] ctl, input logic [7:0] idx, input logic [8:0] a,
                       input logic [7:0] val);
    wr(EEPC_CTL_IDX, {24'h0, ctl | 8'h02});
    wr(EEPC_ADDR_IDX, {23'h0, a});
    wr(idx, {24'h0, val});
    wr(EEPC_CTL_IDX, {24'h0, ctl | 8'h03});
    repeat (PUMP + 4) @(posedge core_clk);
    wr(EEPC_CTL_IDX, 32'h0);
  endtask : nv_op

  task automatic do_reset(input logic [1:0] pins);
    rst_b <= 1'b0;
    {mode_pin_b, mode_pin_a} <= pins;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask : do_reset

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    wrap_up();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rows[0] = '{EEPC_CTL_IDX, 32'hff, 32'hde, EEPC_RESP_OKAY};
    rows[1] = '{EEPC_CTL_IDX, 32'hdf, 32'hdf, EEPC_RESP_OKAY};
    rows[2] = '{EEPC_CTL_IDX, 32'h1d, 32'h1c, EEPC_RESP_OKAY};
    rows[3] = '{EEPC_CTL_IDX, 32'h00, 32'h00, EEPC_RESP_OKAY};
    rows[4] = '{8'h50, 32'h12, 32'h00, EEPC_RESP_SLVERR};
    rows[5] = '{EEPC_BPR_IDX, 32'h00, 32'h00, EEPC_RESP_OKAY};
    // Boot pins, cells still unknown so no wipe: cleared protection lets them be initialised
    do_reset(2'b00);
    wr(EEPC_BPR_IDX, 32'h0);
    nv_op(8'h04, EEPC_DATA_IDX, 9'h000, 8'h00);
    nv_op(8'h04, EEPC_CFG_IDX, 9'h000, 8'h00);
    foreach (rows[i]) begin
      wr(rows[i].idx, rows[i].wv);
      chk("write resp", {30'h0, rows[i].rsp}, {30'h0, wresp});
      rdr(rows[i].idx);
      chk("read data", rows[i].rv, rd);
      chk("read resp", {30'h0, rows[i].rsp}, {30'h0, rresp});
    end
    arr(9'h1a5, 8'hff);
    nv_op(8'hc0, EEPC_DATA_IDX, 9'h003, 8'h77);
    arr(9'h013, 8'h77);
    arr(9'h0f3, 8'h77);
    arr(9'h103, 8'hff);
    nv_op(8'h04, EEPC_DATA_IDX, 9'h1ff, 8'h00);
    arr(9'h0f3, 8'hff);
    // Second target while pumping must be dropped
    wr(EEPC_CTL_IDX, 32'h02);
    wr(EEPC_ADDR_IDX, 32'h010);
    wr(EEPC_DATA_IDX, 32'h5a);
    wr(EEPC_CTL_IDX, 32'h03);
    chk("latch and pump", 32'h3, {30'h0, nv_latch_enable, nv_pump_on});
    wr(EEPC_ADDR_IDX, 32'h011);
    wr(EEPC_DATA_IDX, 32'h00);
    rdr(EEPC_DATA_IDX);
    chk("latched read", 32'h0, rd);
    repeat (PUMP + 4) @(posedge core_clk);
    wr(EEPC_CTL_IDX, 32'h0);
    arr(9'h010, 8'h5a);
    arr(9'h011, 8'hff);
    nv_op(8'h00, EEPC_DATA_IDX, 9'h020, 8'h33);
    nv_op(8'h00, EEPC_DATA_IDX, 9'h021, 8'h44);
    nv_op(8'h1c, EEPC_DATA_IDX, 9'h020, 8'h00);
    arr(9'h020, 8'hff);
    arr(9'h021, 8'h44);
    nv_op(8'h0c, EEPC_DATA_IDX, 9'h01f, 8'h00);
    arr(9'h010, 8'hff);
    arr(9'h021, 8'h44);
    nv_op(8'h18, EEPC_DATA_IDX, 9'h030, 8'h0f);
    arr(9'h030, 8'h0f);
    arr(9'h031, 8'hff);
    wr(EEPC_CFG_IDX, 32'h3c);
    rdr(EEPC_CFG_IDX);
    chk("direct setup", 32'h3c, rd);
    nv_op(8'h00, EEPC_CFG_IDX, 9'h000, 8'h5e);
    rdr(EEPC_CFG_IDX);
    chk("setup before reset", 32'h3c, rd);
    // Single-chip pins: normal mode after this reset
    do_reset(2'b10);
    rdr(EEPC_CFG_IDX);
    chk("setup after reset", 32'h5e, rd);
    chk("setup port", 32'h5e, {24'h0, setup_byte});
    chk("special flag", 32'h0, {31'h0, special_mode_flag});
    chk("mode", {30'h0, EEPC_MODE_SINGLE}, {30'h0, op_mode});
    wr(EEPC_CFG_IDX, 32'h00);
    rdr(EEPC_CFG_IDX);
    chk("setup locked", 32'h5e, rd);
    rdr(EEPC_CTL_IDX);
    chk("ctl reset", {24'h0, EEPC_CTL_RESET}, rd);
    rdr(EEPC_BPR_IDX);
    chk("bpr reset", {24'h0, EEPC_BPR_RESET}, rd);
    arr(9'h030, 8'h0f);
    nv_op(8'h00, EEPC_DATA_IDX, 9'h040, 8'h00);
    arr(9'h040, 8'hff);
    // Arm security in the cells, then start with test pins: wipe must run
    wr(EEPC_BPR_IDX, 32'h0);
    nv_op(8'h04, EEPC_CFG_IDX, 9'h000, 8'h00);
    nv_op(8'h00, EEPC_CFG_IDX, 9'h000, 8'hf7);
    do_reset(2'b01);
    chk("secured mode", {30'h0, EEPC_MODE_BOOT}, {30'h0, op_mode});
    chk("security on", 32'h1, {31'h0, security_on});
    chk("wipe serial", 32'h1ff, {23'h0, serial_tx_valid, serial_tx_data});
    repeat (60) @(posedge core_clk);
    chk("wipe done", 32'h1ff, {23'h0, boot_ready, ram_fill_data});
    rdr(EEPC_BPR_IDX);
    chk("wipe unprotect", 32'h0, rd);
    arr(9'h030, 8'hff);
    do_reset(2'b10);
    rdr(EEPC_CFG_IDX);
    chk("setup wiped", 32'hff, rd);
    wrap_up();
  end
endmodule : eepc_ctrl_bench
